// file: test/fbp_checker.sv
// port assertions for the flash access block
// bound to fbp_top; one clock, async reset
`timescale 1ns/1ps
module fbp_checker (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              rd_req_i,
  input wire fbp_pkg::fbp_src_e rd_src_i,
  input wire logic [14:0]       rd_addr_i,
  input wire logic              rd_ack_o,
  input wire logic              rd_err_o,
  input wire logic [31:0]       rd_data_o,
  input wire logic              ers_req_i,
  input wire logic [4:0]        ers_unit_i,
  input wire logic              busy_o,
  input wire logic              done_o,
  input wire logic              err_o,
  input wire logic [15:0]       ro_i,
  input wire logic [15:0]       xo_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff rst_i;
  wire  lk = ro_i[ers_unit_i[4:1]] | xo_i[ers_unit_i[4:1]];
  wire  dn = rd_req_i && xo_i[rd_addr_i[14:11]] &&
             rd_src_i != fbp_pkg::SRC_FETCH;
  // idle means no erase running and no done pulse standing
  wire  go = ers_req_i && !busy_o && !done_o;
  property p_ack; rd_req_i |=> rd_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("read unanswered");
  property p_nak; !rd_req_i |=> !rd_ack_o && rd_data_o == 0; endproperty
  a_nak: assert property (p_nak) else $error("stray answer");
  property p_dn; dn |=> rd_err_o && rd_data_o == 0; endproperty
  a_dn: assert property (p_dn) else $error("read not denied");
  property p_ok; rd_req_i && !dn |=> !rd_err_o; endproperty
  a_ok: assert property (p_ok) else $error("read denied");
  property p_lk; go && lk |=> done_o && err_o && !busy_o; endproperty
  a_lk: assert property (p_lk) else $error("erase not refused");
  property p_go; go && !lk |=> busy_o && !done_o; endproperty
  a_go: assert property (p_go) else $error("erase not started");
  property p_len; $rose(busy_o) |-> ##256 done_o && !busy_o; endproperty
  a_len: assert property (p_len) else $error("erase length");
  property p_er; err_o |-> done_o; endproperty
  a_er: assert property (p_er) else $error("error without done");
  c_dn: cover property (dn);
  c_lk: cover property (go && lk);
  c_go: cover property (go && !lk);
endmodule // fbp_checker
bind fbp_top fbp_checker chk (.*);

// file: test/fbp_host.sv
// requester model: fetch, data and debug reads
// drives just after an edge, samples the answer one cycle on
`timescale 1ns/1ps
module fbp_host (
  input  wire logic         clk_i,
  input  wire logic         rd_ack_i,
  input  wire logic         rd_err_i,
  input  wire logic [31:0]  rd_data_i,
  output logic              rd_req_o = 0,
  output fbp_pkg::fbp_src_e rd_src_o = fbp_pkg::SRC_DATA,
  output logic [14:0]       rd_addr_o = 0
);
  task automatic rd(input fbp_pkg::fbp_src_e s, input logic [14:0] a,
                    output logic [33:0] r);
    @(posedge clk_i) #1;
    rd_req_o = 1;
    rd_src_o = s;
    rd_addr_o = a;
    @(posedge clk_i) #1;
    rd_req_o = 0;
    rd_addr_o = ~a;
    r = {rd_ack_i, rd_err_i, rd_data_i};
  endtask
endmodule // fbp_host

// file: test/test_flash_block_protection.sv
// self-checking bench for the flash access block
// uses the requester model and the bound checker
`timescale 1ns/1ps
module test_flash_block_protection;
  logic        clk_i = 0, rst_i = 1, pgm_req_i = 0, ers_req_i = 0, e;
  logic        rd_req_i, rd_ack_o, rd_err_o, busy_o, done_o, err_o;
  logic [14:0] rd_addr_i, pgm_addr_i = 0;
  logic [31:0] rd_data_o, pgm_data_i = 0;
  logic [33:0] r;
  logic [4:0]  ers_unit_i = 0;
  logic [15:0] ro_i = 0, xo_i = 0;
  int          miscompares, n_tests, cyc;
  fbp_pkg::fbp_src_e rd_src_i;
  fbp_top uut (.*);
  fbp_host host (.clk_i, .rd_req_o(rd_req_i), .rd_src_o(rd_src_i),
    .rd_addr_o(rd_addr_i), .rd_ack_i(rd_ack_o), .rd_err_i(rd_err_o),
    .rd_data_i(rd_data_o));
  initial forever #10 clk_i = ~clk_i;
  task chk(input logic [33:0] s, x);
    n_tests++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask
  task tally_and_finish;
    $display("%0d checks, %0d bad", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task op(input logic er, input logic [14:0] a, input logic [31:0] v);
    @(posedge clk_i) #1;
    {ers_req_i, pgm_req_i, pgm_addr_i, pgm_data_i} = {er, !er, a, v};
    ers_unit_i = a[14:10];
    @(posedge clk_i) #1;
    {ers_req_i, pgm_req_i} = 0;
    for (int i = 0; i < 300 && !done_o; i++) @(posedge clk_i) #1;
    e = err_o;
    @(posedge clk_i) #1;
  endtask
  task rdc(input fbp_pkg::fbp_src_e s, input logic [14:0] a,
           input logic [32:0] x);
    host.rd(s, a, r);
    chk(r, {1'h1, x});
  endtask
  task t_erase;
    op(1, 15'h0C00, 0);
    op(0, 15'h0C04, 32'h1234ABCD);
    chk({33'h0, e}, 34'h0);
    op(1, 15'h0800, 0);
    rdc(fbp_pkg::SRC_DATA, 15'h0800, 33'hFFFFFFFF);
    rdc(fbp_pkg::SRC_DEBUG, 15'h0C04, 33'h1234ABCD);
    op(1, 15'h7C00, 0);
    rdc(fbp_pkg::SRC_FETCH, 15'h7FFC, 33'hFFFFFFFF);
    $display("erase test done");
  endtask
  task t_ro;
    ro_i = 16'h0002;
    op(0, 15'h0C04, 0);
    chk({33'h0, e}, 34'h1);
    op(1, 15'h0C00, 0);
    chk({33'h0, e}, 34'h1);
    rdc(fbp_pkg::SRC_DEBUG, 15'h0C04, 33'h1234ABCD);
    ro_i = 0;
    $display("read-only test done");
  endtask
  task t_xo;
    xo_i = 16'h0002;
    op(1, 15'h0C00, 0);
    chk({33'h0, e}, 34'h1);
    rdc(fbp_pkg::SRC_FETCH, 15'h0C04, 33'h1234ABCD);
    rdc(fbp_pkg::SRC_DATA, 15'h0C04, 33'h100000000);
    rdc(fbp_pkg::SRC_DEBUG, 15'h0C04, 33'h100000000);
    rdc(fbp_pkg::SRC_DATA, 15'h7FFC, 33'hFFFFFFFF);
    xo_i = 0;
    rdc(fbp_pkg::SRC_DATA, 15'h0C04, 33'h1234ABCD);
    $display("execute-only test done");
  endtask
  always @(posedge clk_i) if (++cyc > 4000) begin
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    #1 rst_i = 0;
    t_erase;
    t_ro;
    t_xo;
    tally_and_finish;
  end
endmodule // test_flash_block_protection

// file: verilog/fbp_pkg.sv
// types of the flash access and protection block
// assumes the constants header is on the include path
package fbp_pkg;

  // requester of a read
  typedef enum logic [1:0] {
    SRC_FETCH,
    SRC_DATA,
    SRC_DEBUG
  } fbp_src_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_DONE
  } fbp_state_e;

  typedef struct packed {
    fbp_state_e  st;
    logic [7:0]  cnt;
    logic [4:0]  unit;
    logic        rd_ack;
    logic        rd_err;
    logic [31:0] rd_data;
    logic        busy;
    logic        done;
    logic        err;
  } fbp_ctl_s;

endpackage

// file: verilog/fbp_regs.svh
// constants of the flash access and protection block
// assumes a 32-bit word array, byte addresses, one system clock
// Summary of operation
// - the array holds 32 KB behind the controller
// - each 1 KB erase unit erases alone, leaving others intact
// - a finished erase leaves every bit of the unit at one
// - protection applies per pair of units, 2 KB regions, each independent
// - each region is read-only, execute-only or unprotected
// - read-only regions refuse erase and program but serve all reads
// - execute-only regions refuse changes and serve instruction fetches only
// - permitted reads complete in one clock with no wait state
`ifndef FBP_REGS_SVH
`define FBP_REGS_SVH

`define FBP_BYTES       32768
`define FBP_ADDR_W      15
`define FBP_WORD_W      32
`define FBP_WIDX_W      13
`define FBP_WORDS       8192
`define FBP_UNIT_W      5
`define FBP_UNIT_WORDS  256
`define FBP_UCNT_W      8
`define FBP_UCNT_LAST   8'hFF
`define FBP_REGIONS     16
`define FBP_REG_W       4
`define FBP_ERASED_WORD 32'hFFFFFFFF
`define FBP_ZERO_WORD   32'h00000000

`endif

// file: verilog/fbp_top.sv
// flash array with erase units, region protection and requester checks
// assumes all inputs are synchronous to clk_i; protection inputs are
// held steady by the system while requests are made
`timescale 1ns/1ps
`include "fbp_regs.svh"

module fbp_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // read port
  input  wire logic                      rd_req_i,
  input  wire fbp_pkg::fbp_src_e         rd_src_i,
  input  wire logic [`FBP_ADDR_W-1:0]    rd_addr_i,
  output logic                           rd_ack_o,
  output logic                           rd_err_o,
  output logic [`FBP_WORD_W-1:0]         rd_data_o,
  // program and erase port
  input  wire logic                      pgm_req_i,
  input  wire logic [`FBP_ADDR_W-1:0]    pgm_addr_i,
  input  wire logic [`FBP_WORD_W-1:0]    pgm_data_i,
  input  wire logic                      ers_req_i,
  input  wire logic [`FBP_UNIT_W-1:0]    ers_unit_i,
  output logic                           busy_o,
  output logic                           done_o,
  output logic                           err_o,
  // per-region protection, one bit per 2 KB region
  input  wire logic [`FBP_REGIONS-1:0]   ro_i,
  input  wire logic [`FBP_REGIONS-1:0]   xo_i
);

  // nonvolatile contents carry no reset; kept outside the state struct
  logic [`FBP_WORD_W-1:0] mem [`FBP_WORDS];

  fbp_pkg::fbp_ctl_s ctl_ff;
  fbp_pkg::fbp_ctl_s nxt_ctl;

  logic                   wr_en;
  logic [`FBP_WIDX_W-1:0] wr_idx;
  logic [`FBP_WORD_W-1:0] wr_val;

  // region of a byte address: two 1 KB units per region
  function automatic logic [`FBP_REG_W-1:0] region_of(
    input logic [`FBP_ADDR_W-1:0] addr
  );
    region_of = addr[`FBP_ADDR_W-1 -: `FBP_REG_W];
  endfunction

  // a region refuses change when read-only or execute-only
  function automatic logic locked(input logic [`FBP_REG_W-1:0] rg,
                                  input logic [`FBP_REGIONS-1:0] ro,
                                  input logic [`FBP_REGIONS-1:0] xo);
    locked = ro[rg] | xo[rg];
  endfunction

  function automatic logic [`FBP_WIDX_W-1:0] word_of(
    input logic [`FBP_ADDR_W-1:0] addr
  );
    word_of = addr[`FBP_ADDR_W-1:2];
  endfunction

  always_comb begin
    logic [`FBP_REG_W-1:0] rrg;
    logic                  rd_ok;
    rrg   = region_of(rd_addr_i);
    rd_ok = 1'b0;
    nxt_ctl = ctl_ff;
    wr_en   = 1'b0;
    wr_idx  = word_of(pgm_addr_i);
    wr_val  = mem[word_of(pgm_addr_i)] & pgm_data_i;

    // read side: answer on the next edge, always one cycle
    // execute-only wins over read-only when both are set
    if (xo_i[rrg]) begin
      rd_ok = (rd_src_i == fbp_pkg::SRC_FETCH);
    end else begin
      rd_ok = 1'b1;
    end
    nxt_ctl.rd_ack  = rd_req_i;
    nxt_ctl.rd_err  = rd_req_i & ~rd_ok;
    if (rd_req_i && rd_ok) begin
      nxt_ctl.rd_data = mem[word_of(rd_addr_i)];
    end else begin
      nxt_ctl.rd_data = `FBP_ZERO_WORD;
    end

    nxt_ctl.done = 1'b0;
    nxt_ctl.err  = 1'b0;

    case (ctl_ff.st)
      fbp_pkg::ST_IDLE: begin
        if (ers_req_i) begin
          if (locked(ers_unit_i[`FBP_UNIT_W-1:1], ro_i, xo_i)) begin
            nxt_ctl.st   = fbp_pkg::ST_DONE;
            nxt_ctl.err  = 1'b1;
            nxt_ctl.done = 1'b1;
          end else begin
            nxt_ctl.st   = fbp_pkg::ST_ERASE;
            nxt_ctl.unit = ers_unit_i;
            nxt_ctl.cnt  = 8'h00;
            nxt_ctl.busy = 1'b1;
          end
        end else if (pgm_req_i) begin
          nxt_ctl.st   = fbp_pkg::ST_DONE;
          nxt_ctl.done = 1'b1;
          if (locked(region_of(pgm_addr_i), ro_i, xo_i)) begin
            nxt_ctl.err = 1'b1;
          end else begin
            // programming can only clear bits; ones come from erase
            wr_en = 1'b1;
          end
        end
      end
      fbp_pkg::ST_ERASE: begin
        // one word per clock, confined to the selected unit
        wr_en  = 1'b1;
        wr_idx = {ctl_ff.unit, ctl_ff.cnt};
        wr_val = `FBP_ERASED_WORD;
        nxt_ctl.cnt = ctl_ff.cnt + 8'h01;
        if (ctl_ff.cnt == `FBP_UCNT_LAST) begin
          nxt_ctl.st   = fbp_pkg::ST_DONE;
          nxt_ctl.busy = 1'b0;
          nxt_ctl.done = 1'b1;
        end
      end
      fbp_pkg::ST_DONE: begin
        // one idle clock lets the done pulse drop before the next request
        nxt_ctl.st = fbp_pkg::ST_IDLE;
      end
      default: begin
        nxt_ctl.st   = fbp_pkg::ST_IDLE;
        nxt_ctl.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_ff <= '{st: fbp_pkg::ST_IDLE, cnt: 8'h00, unit: 5'h00,
                 rd_ack: 1'b0, rd_err: 1'b0, rd_data: 32'h00000000,
                 busy: 1'b0, done: 1'b0, err: 1'b0};
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_val;
    end
  end

  assign rd_ack_o  = ctl_ff.rd_ack;
  assign rd_err_o  = ctl_ff.rd_err;
  assign rd_data_o = ctl_ff.rd_data;
  assign busy_o    = ctl_ff.busy;
  assign done_o    = ctl_ff.done;
  assign err_o     = ctl_ff.err;

endmodule // fbp_top
